// ===== logic/upr_consts.svh
`ifndef UPR_CONSTS_SVH
`define UPR_CONSTS_SVH

// -----------------------------------------------------------------------------
// register map: 4 groups x 4 pin pairs, index = group*4 + pair, byte addr = idx*4
// -----------------------------------------------------------------------------
`define UPR_ADDR_W        8
`define UPR_REG_BASE      8'h00
`define UPR_REG_LAST      8'h3c
`define UPR_REG_RESET     16'h0000

// -----------------------------------------------------------------------------
// slot field positions inside one byte
// -----------------------------------------------------------------------------
`define UPR_SLOT_ODD_LSB  4'h8
`define UPR_FNC_MSB       7
`define UPR_FNC_LSB       5
`define UPR_CH_MSB        4
`define UPR_CH_LSB        3
`define UPR_UNIT_MSB      2
`define UPR_UNIT_LSB      0

// -----------------------------------------------------------------------------
// peripheral codes and channel limits
// -----------------------------------------------------------------------------
`define UPR_UNIT_NONE     3'h0
`define UPR_UNIT_I2C      3'h1
`define UPR_UNIT_SPI      3'h2
`define UPR_UNIT_UART     3'h3
`define UPR_UNIT_TMR      3'h4
`define UPR_CH_MAX_SER    2'h2
`define UPR_CH_MAX_TMR    2'h1
`define UPR_FNC_MUX_SLOT  2'h1

`endif

// ===== logic/upr_pkg.sv
package upr_pkg;
    typedef enum logic [4:0] {
        UPR_SIG_NONE = 5'h00,
        UPR_SIG_IN   = 5'h01,
        UPR_SIG_OUT  = 5'h02
    } upr_dir_e;
    typedef logic [15:0] upr_reg_t;
endpackage

// ===== logic/upr_universal_pin_router.sv
// Contract
// - each register holds the even pin slot in bits 7-0 and the odd pin slot in 15-8, function 3 bits on top, channel 2, unit 3 at the bottom.
// - unit code 0 is none, 1 i2c, 2 sync serial, 3 uart, 4 timer, 5 to 7 reserved.
// - channel selects the instance, 0 to 2 for the serial units and 0 to 1 for the timer.
// - function picks the signal per unit: i2c clk/data, spi in/out/clk/select, uart rx/tx, timer lines 0 to 3.
// - function 0 or unit 0 means no assignment and the pin floats when slot 1 is selected and enabled.
// - the router feeds only function slot 1 of each pin and leaves other slots alone.
// - a routed signal reaches the pin only while the pin's function slot select is 1.
// - programmable routing exists only for port groups 0 to 3.
// - each group has four registers covering eight pins as four pairs.
// - one output routed to several pins drives the same waveform on each of them.
`timescale 1ns/1ps
`include "upr_consts.svh"

module upr_universal_pin_router
    import upr_pkg::*;
#(
    parameter int NPIN = 32
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [15:0]       reg_rdata,
    // port state per pin, groups 0..3 x 8 pins
    input  wire logic [NPIN-1:0]   pin_peripheral_mode,
    input  wire logic [2*NPIN-1:0] pin_function_slot,
    input  wire logic [NPIN-1:0]   pin_in,
    output logic      [NPIN-1:0]   pin_out,
    output logic      [NPIN-1:0]   pin_oe,
    // peripheral outputs toward pins
    input  wire logic [2:0]        i2c_scl_out,
    input  wire logic [2:0]        i2c_sda_out,
    input  wire logic [2:0]        i2c_scl_oe,
    input  wire logic [2:0]        i2c_sda_oe,
    input  wire logic [2:0]        serial_data_out_line,
    input  wire logic [2:0]        serial_clock_line_out,
    input  wire logic [2:0]        serial_select_line_out,
    input  wire logic [2:0]        uart_transmit_line,
    input  wire logic [7:0]        timer_out_capture_line,
    input  wire logic [7:0]        timer_line_oe,
    // pin levels toward peripherals
    output logic      [2:0]        i2c_scl_in,
    output logic      [2:0]        i2c_sda_in,
    output logic      [2:0]        serial_data_in_line,
    output logic      [2:0]        serial_clock_line_in,
    output logic      [2:0]        serial_select_line_in,
    output logic      [2:0]        uart_receive_line,
    output logic      [7:0]        timer_capture_in
);

    // -------------------------------------------------------------------------
    // setting registers
    // -------------------------------------------------------------------------
    upr_reg_t route [16];
    logic [NPIN-1:0] sync1, sync2, sync3, pin_lvl;

    wire       addr_hit = (reg_addr[1:0] == 2'h0) && (reg_addr <= `UPR_REG_LAST);
    wire [3:0] addr_idx = reg_addr[5:2];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) route[i] <= `UPR_REG_RESET;
        end else if (reg_write && addr_hit) begin
            route[addr_idx] <= reg_wdata;
        end
    end

    // unmapped reads return zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= addr_hit ? route[addr_idx] : 16'h0000;
        end
    end

    // -------------------------------------------------------------------------
    // pin input synchroniser; stage 1 feeds only stage 2
    // -------------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1   <= '0;
            sync2   <= '0;
            sync3   <= '0;
            pin_lvl <= '0;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            for (int p = 0; p < NPIN; p++) begin
                if (sync2[p] == sync3[p]) pin_lvl[p] <= sync3[p];
            end
        end
    end

    // -------------------------------------------------------------------------
    // slot decode
    // -------------------------------------------------------------------------
    function automatic logic [7:0] slot_of(input int p, input upr_reg_t r);
        slot_of = p[0] ? r[15:8] : r[7:0];
    endfunction

    // valid assignment: legal unit, channel and function, else nothing routed
    function automatic logic slot_valid(input logic [7:0] s);
        logic [2:0] u;
        logic [1:0] c;
        logic [2:0] f;
        u = s[`UPR_UNIT_MSB:`UPR_UNIT_LSB];
        c = s[`UPR_CH_MSB:`UPR_CH_LSB];
        f = s[`UPR_FNC_MSB:`UPR_FNC_LSB];
        case (u)
            `UPR_UNIT_I2C:  slot_valid = (c <= `UPR_CH_MAX_SER) && (f == 3'h1 || f == 3'h2);
            `UPR_UNIT_SPI:  slot_valid = (c <= `UPR_CH_MAX_SER) && (f >= 3'h1 && f <= 3'h4);
            `UPR_UNIT_UART: slot_valid = (c <= `UPR_CH_MAX_SER) && (f == 3'h1 || f == 3'h2);
            `UPR_UNIT_TMR:  slot_valid = (c <= `UPR_CH_MAX_TMR) && (f >= 3'h1 && f <= 3'h4);
            default:        slot_valid = 1'b0;
        endcase
    endfunction

    // -------------------------------------------------------------------------
    // output side: pin driven only in peripheral mode, slot 1, valid route
    // -------------------------------------------------------------------------
    logic [7:0] slot   [NPIN];
    logic [NPIN-1:0] active;
    logic [NPIN-1:0] next_out, next_oe;

    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            logic [1:0] c;
            logic [2:0] f;
            slot[p]   = slot_of(p, route[p/2]);
            c         = slot[p][`UPR_CH_MSB:`UPR_CH_LSB];
            f         = slot[p][`UPR_FNC_MSB:`UPR_FNC_LSB];
            active[p] = pin_peripheral_mode[p] && (pin_function_slot[2*p +: 2] == `UPR_FNC_MUX_SLOT)
                        && slot_valid(slot[p]);
            next_out[p] = 1'b0;
            next_oe[p]  = 1'b0;
            if (active[p]) begin
                case (slot[p][`UPR_UNIT_MSB:`UPR_UNIT_LSB])
                    `UPR_UNIT_I2C: begin
                        next_out[p] = (f == 3'h1) ? i2c_scl_out[c] : i2c_sda_out[c];
                        next_oe[p]  = (f == 3'h1) ? i2c_scl_oe[c] : i2c_sda_oe[c];
                    end
                    `UPR_UNIT_SPI: begin
                        next_out[p] = (f == 3'h2) ? serial_data_out_line[c] :
                                      (f == 3'h3) ? serial_clock_line_out[c] : serial_select_line_out[c];
                        next_oe[p]  = (f != 3'h1);
                    end
                    `UPR_UNIT_UART: begin
                        next_out[p] = uart_transmit_line[c];
                        next_oe[p]  = (f == 3'h2);
                    end
                    default: begin
                        next_out[p] = timer_out_capture_line[{c[0], 2'(f - 3'h1)}];
                        next_oe[p]  = timer_line_oe[{c[0], 2'(f - 3'h1)}];
                    end
                endcase
            end
        end
    end

    // registered pins: every pin sees the same one-cycle latency
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_out <= '0;
            pin_oe  <= '0;
        end else begin
            pin_out <= next_out;
            pin_oe  <= next_oe;
        end
    end

    // -------------------------------------------------------------------------
    // input side: idle levels when unrouted (high for serial, low for timer)
    // -------------------------------------------------------------------------
    // if software breaks the single-source rule the lowest pin number wins
    always_comb begin
        i2c_scl_in            = 3'h7;
        i2c_sda_in            = 3'h7;
        serial_data_in_line   = 3'h7;
        serial_clock_line_in  = 3'h7;
        serial_select_line_in = 3'h7;
        uart_receive_line     = 3'h7;
        timer_capture_in      = 8'h00;
        for (int p = NPIN - 1; p >= 0; p--) begin
            logic [1:0] c;
            logic [2:0] f;
            c = slot[p][`UPR_CH_MSB:`UPR_CH_LSB];
            f = slot[p][`UPR_FNC_MSB:`UPR_FNC_LSB];
            if (active[p]) begin
                case (slot[p][`UPR_UNIT_MSB:`UPR_UNIT_LSB])
                    `UPR_UNIT_I2C: begin
                        if (f == 3'h1) i2c_scl_in[c] = pin_lvl[p];
                        else i2c_sda_in[c] = pin_lvl[p];
                    end
                    `UPR_UNIT_SPI: begin
                        if (f == 3'h1) serial_data_in_line[c] = pin_lvl[p];
                        else if (f == 3'h3) serial_clock_line_in[c] = pin_lvl[p];
                        else if (f == 3'h4) serial_select_line_in[c] = pin_lvl[p];
                    end
                    `UPR_UNIT_UART: begin
                        if (f == 3'h1) uart_receive_line[c] = pin_lvl[p];
                    end
                    default: timer_capture_in[{c[0], 2'(f - 3'h1)}] = pin_lvl[p];
                endcase
            end
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    property p_float_when_idle;
        @(posedge clk) disable iff (!resetn) !active[0] |=> !pin_oe[0];
    endproperty
    a_float_when_idle: assert property (p_float_when_idle) else $error("pin 0 driven without route");

    property p_slot_gate;
        @(posedge clk) disable iff (!resetn)
            (pin_function_slot[1:0] != `UPR_FNC_MUX_SLOT) |=> !pin_oe[0];
    endproperty
    a_slot_gate: assert property (p_slot_gate) else $error("pin 0 driven outside slot 1");

    property p_mode_gate;
        @(posedge clk) disable iff (!resetn) !pin_peripheral_mode[1] |=> !pin_oe[1];
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("pin 1 driven outside peripheral mode");

    property p_reserved_unit;
        @(posedge clk) disable iff (!resetn) (route[0][2:0] > `UPR_UNIT_TMR) |=> !pin_oe[0];
    endproperty
    a_reserved_unit: assert property (p_reserved_unit) else $error("reserved unit drove pin 0");

    property p_reserved_chan;
        @(posedge clk) disable iff (!resetn) (route[0][2:0] == `UPR_UNIT_TMR && route[0][4:3] > 2'h1)
            |=> !pin_oe[0];
    endproperty
    a_reserved_chan: assert property (p_reserved_chan) else $error("bad timer channel drove pin 0");

    property p_uart_tx;
        @(posedge clk) disable iff (!resetn)
            (active[0] && route[0][7:0] == 8'h43) |=> (pin_oe[0] && pin_out[0] == $past(uart_transmit_line[0]));
    endproperty
    a_uart_tx: assert property (p_uart_tx) else $error("uart tx not on pin 0");

    property p_write_read;
        @(posedge clk) disable iff (!resetn)
            (reg_write && reg_addr == 8'h04) ##1 (reg_read && reg_addr == 8'h04 && !reg_write)
            |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_write_read: assert property (p_write_read) else $error("setting register readback wrong");

    property p_unmapped;
        @(posedge clk) disable iff (!resetn) (reg_read && reg_addr > `UPR_REG_LAST) |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_rx_idle;
        @(posedge clk) disable iff (!resetn) (active == '0) |-> uart_receive_line == 3'h7;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("unrouted uart input not idle");

    c_pin0_drive: cover property (@(posedge clk) disable iff (!resetn) pin_oe[0]);
    c_uart_rx:    cover property (@(posedge clk) disable iff (!resetn) uart_receive_line != 3'h7);
    c_timer_out:  cover property (@(posedge clk) disable iff (!resetn) active[2] && route[1][2:0] == 3'h4);

endmodule

// ===== testbench/upr_periph_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// peripheral controllers on the far side of the router
// -----------------------------------------------------------------------------
module upr_periph_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // output levels and enables the bench wants the controllers to present
    input  wire logic [39:0] pat,
    // controller outputs toward the router
    output logic      [39:0] drv
);
    // launched just after the edge, like real controller flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            drv <= 40'h0;
        end else begin
            drv <= pat;
        end
    end
endmodule

// ===== testbench/universal_port_peripheral_mux_tb.sv
`timescale 1ns/1ps
module universal_port_peripheral_mux_tb
    import upr_pkg::*;
;
    typedef struct {int src; logic [31:0] e; logic [31:0] m;} upr_note_s;
    logic        clk, resetn, reg_write, reg_read, rd_d;
    logic [7:0]  reg_addr, timer_out_capture_line, timer_line_oe, timer_capture_in;
    logic [15:0] reg_wdata, reg_rdata;
    logic [31:0] pin_peripheral_mode, pin_in, pin_out, pin_oe;
    logic [63:0] pin_function_slot;
    logic [2:0]  i2c_scl_out, i2c_sda_out, i2c_scl_oe, i2c_sda_oe, serial_data_out_line, serial_clock_line_out;
    logic [2:0]  serial_select_line_out, uart_transmit_line, i2c_scl_in, i2c_sda_in, serial_data_in_line;
    logic [2:0]  serial_clock_line_in, serial_select_line_in, uart_receive_line;
    logic [39:0] pat, drv;
    upr_reg_t    regs [16];
    upr_note_s   q [$];
    upr_note_s   n;
    int          mismatches, n_tests, cyc;

    assign {i2c_scl_out, i2c_sda_out, i2c_scl_oe, i2c_sda_oe, serial_data_out_line, serial_clock_line_out,
            serial_select_line_out, uart_transmit_line, timer_out_capture_line, timer_line_oe} = drv;

    upr_periph_model peri (.clk, .resetn, .pat, .drv);
    upr_universal_pin_router #(.NPIN(32)) DUT (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .pin_peripheral_mode, .pin_function_slot, .pin_in, .pin_out, .pin_oe, .i2c_scl_out,
        .i2c_sda_out, .i2c_scl_oe, .i2c_sda_oe, .serial_data_out_line, .serial_clock_line_out,
        .serial_select_line_out, .uart_transmit_line, .timer_out_capture_line, .timer_line_oe, .i2c_scl_in,
        .i2c_sda_in, .serial_data_in_line, .serial_clock_line_in, .serial_select_line_in, .uart_receive_line,
        .timer_capture_in);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // -------------------------------------------------------------------------
    // expected {oe, out} of one pin from its slot byte and the controller word
    // -------------------------------------------------------------------------
    function automatic logic [1:0] pexp(input logic [7:0] b, input logic en, input logic [39:0] p);
        logic [2:0] u;
        logic [1:0] c;
        logic [2:0] f;
        logic [3:0] t;
        u = b[2:0];
        c = b[4:3];
        f = b[7:5];
        t = 4'(c * 4 + f - 1);
        pexp = 2'b00;
        if (en && f != 0 && ((u inside {1, 2, 3} && c <= 2) || (u == 4 && c <= 1))) begin
            case (u)
                1: pexp = (f == 1) ? {p[31+c], p[37+c]} : (f == 2) ? {p[28+c], p[34+c]} : 2'b00;
                2: pexp = (f inside {2, 3, 4}) ? {1'b1, p[25-3*(f-2)+c]} : 2'b00;
                3: pexp = (f == 2) ? {1'b1, p[16+c]} : 2'b00;
                default: pexp = (f <= 4) ? {p[t], p[8+t]} : 2'b00;
            endcase
        end
    endfunction

    function automatic logic [31:0] obs(input int s);
        case (s)
            0: obs = {16'h0, reg_rdata};
            1: obs = pin_oe;
            2: obs = pin_out;
            3: obs = {14'h0, i2c_scl_in, i2c_sda_in, serial_data_in_line, serial_clock_line_in,
                      serial_select_line_in, uart_receive_line};
            default: obs = {24'h0, timer_capture_in};
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic note(input int s, input logic [31:0] e, input logic [31:0] m);
        q.push_back('{s, e, m});
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        reg_addr <= a;
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        note(0, {16'h0, e}, 32'hffff);
        @(posedge clk);
    endtask

    task automatic idle(input int k);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        repeat (k) @(posedge clk);
    endtask

    task automatic rand_route();
        logic [31:0] m, eo, eq;
        logic [63:0] s;
        logic [39:0] pt;
        logic [7:0]  b;
        logic [1:0]  e;
        m = $urandom;
        s = {$urandom, $urandom};
        pt = {8'($urandom), $urandom};
        pin_peripheral_mode <= '0;
        for (int i = 0; i < 16; i++) begin
            regs[i] = 16'($urandom);
            wr(8'(i * 4), regs[i]);
        end
        pat <= pt;
        pin_function_slot <= s;
        idle(1);
        pin_peripheral_mode <= m;
        idle(4);
        for (int p = 0; p < 32; p++) begin
            b = p[0] ? regs[p/2][15:8] : regs[p/2][7:0];
            e = pexp(b, m[p] && s[2*p +: 2] == 2'h1, pt);
            eo[p] = e[1];
            eq[p] = e[0];
        end
        note(1, eo, '1);
        note(2, eq, eo);
    endtask

    // results are compared by this watcher in the order they were noted
    always @(posedge clk) begin
        rd_d <= reg_read;
        if (rd_d && q.size() > 0) begin
            n = q.pop_front();
            check(obs(n.src) & n.m, n.e & n.m);
        end
        while (q.size() > 0 && q[0].src != 0) begin
            n = q.pop_front();
            check(obs(n.src) & n.m, n.e & n.m);
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] pi;
        void'($urandom(4));
        {resetn, reg_write, reg_read, reg_addr, reg_wdata, pin_in, pat} = '0;
        {pin_peripheral_mode, pin_function_slot} = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        note(1, 0, '1);
        note(3, 32'h3ffff, '1);
        note(4, 0, '1);
        for (int i = 0; i < 16; i++) rd(8'(i * 4), 16'h0000);
        for (int i = 0; i < 16; i++) begin
            regs[i] = 16'($urandom);
            wr(8'(i * 4), regs[i]);
        end
        wr(8'h05, 16'hffff);
        wr(8'h40, 16'hffff);
        for (int i = 0; i < 16; i++) rd(8'(i * 4), regs[i]);
        rd(8'h40, 16'h0000);
        // write followed at once by a read of the same register
        regs[1] = 16'($urandom);
        wr(8'h04, regs[1]);
        rd(8'h04, regs[1]);
        idle(3);
        repeat (40) rand_route();
        // one pin per peripheral input, so no input has two sources
        pin_peripheral_mode <= '0;
        regs = '{0: 16'h5143, 1: 16'h8a62, 2: 16'h0021, 4: 16'h2b00, 10: 16'h006c, 15: 16'h3200,
                 default: 16'h0000};
        for (int i = 0; i < 16; i++) wr(8'(i * 4), regs[i]);
        pin_function_slot <= (64'h1 << 18) | (64'h1 << 40) | (64'h1 << 62) | 64'h155;
        idle(1);
        pin_peripheral_mode <= 32'h8010_021f;
        repeat (6) begin
            pi = $urandom;
            pin_in <= pi;
            idle(6);
            note(3, 32'h3ffff & ~32'hc852 | {16'h0, pi[4], pi[1], 2'h0, pi[31], 4'h0, pi[2], 1'b0, pi[3],
                 2'h0, pi[9], 1'b0}, '1);
            note(4, {25'h0, pi[20], 6'h0}, '1);
            note(1, 32'h1, 32'h1);
            note(2, {31'h0, pat[16]}, 32'h1);
        end
        idle(3);
        end_of_test();
    end
endmodule
